// File: verilog/uss_ctrl.sv
/*
 * uart shadow control top: apb register file holding line, modem and
 * queue control, single-field aliases of line and queue control, event status and mask,
 * queue reset pulses, and the line and threshold submodules.
 * assumes an apb master in the clk domain and queues that reset their
 * control state on the one-cycle reset pulses.
 */
`timescale 1ns/1ps
module uss_ctrl #(
	parameter int DEPTH = uss_pkg::USS_QUEUE_DEPTH,
	parameter int LW = $clog2(DEPTH) + 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_serial,
	input wire logic [LW-1:0] rx_level,
	input wire logic [LW-1:0] tx_level,
	output logic sout,
	output logic sir_out_n,
	output logic loop_rx,
	output logic queue_en,
	output logic tx_queue_reset,
	output logic rx_queue_reset,
	output logic dma_rx_req_n,
	output logic dma_tx_req_n,
	output logic irq
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [7:0] line_control_reg;
		logic [7:0] modem_control_reg;
		logic dma_mode;
		logic fifo_en;
		logic [1:0] rx_trig;
		logic [uss_pkg::USS_EV_W-1:0] status;
		logic [uss_pkg::USS_EV_W-1:0] mask;
		logic irq;
		logic txq_rst;
		logic rxq_rst;
		logic avail_d;
	} uss_ctrl_state_t;
	uss_ctrl_state_t s_r, s_nxt;

	logic acc;
	logic hit;
	logic commit;
	logic [31:0] rd;
	logic [uss_pkg::USS_EV_W-1:0] ev;
	logic rx_avail;

	// -----------------------------------------------------------------
	// read decode
	// -----------------------------------------------------------------
	always_comb begin
		hit = 1'b1;
		rd = 32'h0000_0000;
		unique case (paddr)
			uss_pkg::USS_BREAK_ALIAS_ADDR: rd[0] = s_r.line_control_reg[uss_pkg::USS_LCR_BREAK_BIT]; // [RULE15]
			uss_pkg::USS_DMA_ALIAS_ADDR: rd[0] = s_r.dma_mode; // [RULE15]
			uss_pkg::USS_QEN_ALIAS_ADDR: rd[0] = s_r.fifo_en; // [RULE15]
			uss_pkg::USS_RXTH_ALIAS_ADDR: rd[1:0] = s_r.rx_trig; // [RULE15]
			uss_pkg::USS_LCR_ADDR: rd[7:0] = s_r.line_control_reg;
			uss_pkg::USS_MCR_ADDR: rd[7:0] = s_r.modem_control_reg;
			uss_pkg::USS_QCR_ADDR: begin
				rd[uss_pkg::USS_QCR_EN_BIT] = s_r.fifo_en;
				rd[uss_pkg::USS_QCR_DMA_BIT] = s_r.dma_mode;
				rd[uss_pkg::USS_QCR_TRIG_LSB +: 2] = s_r.rx_trig;
			end
			uss_pkg::USS_STATUS_ADDR: rd[uss_pkg::USS_EV_W-1:0] = s_r.status;
			uss_pkg::USS_MASK_ADDR: rd[uss_pkg::USS_EV_W-1:0] = s_r.mask;
			default: hit = 1'b0;
		endcase
	end

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		acc = psel & penable;
		commit = acc & s_r.pready & pwrite & hit;
		s_nxt.txq_rst = 1'b0;
		s_nxt.rxq_rst = 1'b0;
		// one wait state: answer in the second access cycle
		if (acc && !s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = ~hit;
			s_nxt.prdata = (pwrite || !hit) ? 32'h0000_0000 : rd;
		end else begin
			s_nxt.pready = 1'b0;
			s_nxt.pslverr = 1'b0;
		end
		if (commit) begin
			unique case (paddr)
				uss_pkg::USS_BREAK_ALIAS_ADDR: begin
					s_nxt.line_control_reg[uss_pkg::USS_LCR_BREAK_BIT] = pwdata[0]; // [RULE1]
				end
				uss_pkg::USS_DMA_ALIAS_ADDR: s_nxt.dma_mode = pwdata[0]; // [RULE6]
				uss_pkg::USS_QEN_ALIAS_ADDR: s_nxt.fifo_en = pwdata[0]; // [RULE8]
				uss_pkg::USS_RXTH_ALIAS_ADDR: s_nxt.rx_trig = pwdata[1:0]; // [RULE11]
				uss_pkg::USS_LCR_ADDR: s_nxt.line_control_reg = pwdata[7:0]; // [RULE1]
				uss_pkg::USS_MCR_ADDR: s_nxt.modem_control_reg = pwdata[7:0];
				uss_pkg::USS_QCR_ADDR: begin
					s_nxt.fifo_en = pwdata[uss_pkg::USS_QCR_EN_BIT];
					s_nxt.dma_mode = pwdata[uss_pkg::USS_QCR_DMA_BIT];
					s_nxt.rx_trig = pwdata[uss_pkg::USS_QCR_TRIG_LSB +: 2];
				end
				uss_pkg::USS_STATUS_ADDR: begin
					s_nxt.status = s_r.status & ~pwdata[uss_pkg::USS_EV_W-1:0];
				end
				uss_pkg::USS_MASK_ADDR: s_nxt.mask = pwdata[uss_pkg::USS_EV_W-1:0];
				default: s_nxt.mask = s_r.mask;
			endcase
		end
		// disabling the queues clears both control portions
		if (s_r.fifo_en && !s_nxt.fifo_en) begin // [RULE10]
			s_nxt.txq_rst = 1'b1;
			s_nxt.rxq_rst = 1'b1;
		end
		ev = '0;
		s_nxt.avail_d = rx_avail;
		ev[uss_pkg::USS_EV_RX_AVAIL] = rx_avail & ~s_r.avail_d; // [RULE13]
		ev[uss_pkg::USS_EV_QRESET] = s_nxt.txq_rst;
		// a new event wins over a clear in the same cycle
		s_nxt.status = s_nxt.status | ev;
		s_nxt.irq = |(s_nxt.status & s_nxt.mask);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
				line_control_reg: uss_pkg::USS_LCR_RST, modem_control_reg: uss_pkg::USS_MCR_RST,
				dma_mode: 1'b0, fifo_en: 1'b0, rx_trig: uss_pkg::USS_TRIG_RST,
				status: '0, mask: '0, irq: 1'b0, txq_rst: 1'b0, rxq_rst: 1'b0,
				avail_d: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// -----------------------------------------------------------------
	// outputs and submodules
	// -----------------------------------------------------------------
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign queue_en = s_r.fifo_en; // [RULE9]
	assign tx_queue_reset = s_r.txq_rst;
	assign rx_queue_reset = s_r.rxq_rst;
	assign irq = s_r.irq;

	uss_line_drv u_line (
		.clk(clk),
		.rst(rst),
		.brk(s_r.line_control_reg[uss_pkg::USS_LCR_BREAK_BIT]),
		.loopback(s_r.modem_control_reg[uss_pkg::USS_MCR_LOOP_BIT]),
		.sir_mode(s_r.modem_control_reg[uss_pkg::USS_MCR_SIR_BIT]),
		.tx_serial(tx_serial),
		.sout(sout),
		.sir_out_n(sir_out_n),
		.loop_rx(loop_rx)
	);

	uss_rx_thresh #(
		.DEPTH(DEPTH),
		.LW(LW)
	) u_thresh (
		.clk(clk),
		.rst(rst),
		.rx_threshold_select(s_r.rx_trig),
		.queue_en(s_r.fifo_en),
		.dma_mode(s_r.dma_mode),
		.rx_level(rx_level),
		.tx_level(tx_level),
		.rx_avail(rx_avail),
		.dma_rx_req_n(dma_rx_req_n),
		.dma_tx_req_n(dma_tx_req_n)
	);

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	apb_wait_a: assert property (acc && !pready |=> pready ##1 !pready)
		else $error("apb answer timing wrong");
	apb_unmapped_a: assert property (acc && !pready && !hit |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not flagged");
	break_alias_a: assert property (commit && paddr == uss_pkg::USS_BREAK_ALIAS_ADDR // [RULE1]
		|=> s_r.line_control_reg[uss_pkg::USS_LCR_BREAK_BIT] == $past(pwdata[0]) && s_r.modem_control_reg == $past(s_r.modem_control_reg))
		else $error("break alias mismatch");
	dma_alias_a: assert property (commit && paddr == uss_pkg::USS_DMA_ALIAS_ADDR // [RULE6]
		|=> s_r.dma_mode == $past(pwdata[0]) && $stable(s_r.rx_trig) && $stable(s_r.fifo_en))
		else $error("dma alias touched other bits");
	qen_alias_a: assert property (commit && paddr == uss_pkg::USS_QEN_ALIAS_ADDR // [RULE8]
		|=> queue_en == $past(pwdata[0]) && $stable(s_r.dma_mode) && $stable(s_r.rx_trig))
		else $error("enable alias touched other bits");
	trig_alias_a: assert property (commit && paddr == uss_pkg::USS_RXTH_ALIAS_ADDR // [RULE11]
		|=> s_r.rx_trig == $past(pwdata[1:0]) && $stable(s_r.fifo_en) && $stable(s_r.dma_mode))
		else $error("trigger alias touched other bits");
	queue_reset_a: assert property ($fell(queue_en) |-> tx_queue_reset && rx_queue_reset // [RULE10]
		##1 !tx_queue_reset && !rx_queue_reset)
		else $error("queue reset pulse wrong");
	no_spur_reset_a: assert property (tx_queue_reset |-> $past(queue_en) && !queue_en) // [RULE10]
		else $error("spurious queue reset");
	alias_upper_a: assert property (acc && !pready && !pwrite // [RULE15]
		&& (paddr == uss_pkg::USS_BREAK_ALIAS_ADDR
		|| paddr == uss_pkg::USS_RXTH_ALIAS_ADDR) |=> prdata[31:2] == 30'h0)
		else $error("alias upper bits not zero");
	irq_level_a: assert property (|(s_r.status & s_r.mask) |-> irq)
		else $error("interrupt not raised");
	status_sticky_a: assert property (s_r.status[uss_pkg::USS_EV_QRESET] && !commit
		|=> s_r.status[uss_pkg::USS_EV_QRESET])
		else $error("status bit dropped");

	// -----------------------------------------------------------------
	// register file checks
	// -----------------------------------------------------------------
	lcr_hold_a: assert property (!commit // [RULE1]
		|=> $stable(s_r.line_control_reg) && $stable(s_r.modem_control_reg))
		else $error("control changed without write");
	qcr_hold_a: assert property (!commit // [RULE6]
		|=> $stable(s_r.dma_mode) && $stable(s_r.rx_trig))
		else $error("queue control changed without write");
	qen_hold_a: assert property (!commit // [RULE8]
		|=> $stable(s_r.fifo_en))
		else $error("enable changed without write");
	mask_hold_a: assert property (!commit
		|=> $stable(s_r.mask))
		else $error("mask changed without write");
	lcr_write_a: assert property (commit && paddr == uss_pkg::USS_LCR_ADDR // [RULE1]
		|=> s_r.line_control_reg == $past(pwdata[7:0]))
		else $error("line control write lost");
	qcr_write_a: assert property (commit && paddr == uss_pkg::USS_QCR_ADDR // [RULE11]
		|=> s_r.rx_trig == $past(pwdata[uss_pkg::USS_QCR_TRIG_LSB +: 2]))
		else $error("queue control trigger write lost");
	qcr_en_write_a: assert property (commit && paddr == uss_pkg::USS_QCR_ADDR // [RULE8]
		|=> queue_en == $past(pwdata[uss_pkg::USS_QCR_EN_BIT]))
		else $error("queue control enable write lost");
	qcr_dma_write_a: assert property (commit && paddr == uss_pkg::USS_QCR_ADDR // [RULE7]
		|=> s_r.dma_mode == $past(pwdata[uss_pkg::USS_QCR_DMA_BIT]))
		else $error("queue control dma write lost");
	rd_break_a: assert property (acc && !pready && !pwrite && paddr == uss_pkg::USS_BREAK_ALIAS_ADDR // [RULE15]
		|=> prdata == {31'h0, $past(s_r.line_control_reg[uss_pkg::USS_LCR_BREAK_BIT])})
		else $error("break alias read wrong");
	rd_dma_a: assert property (acc && !pready && !pwrite && paddr == uss_pkg::USS_DMA_ALIAS_ADDR // [RULE15]
		|=> prdata == {31'h0, $past(s_r.dma_mode)})
		else $error("dma alias read wrong");
	rd_qen_a: assert property (acc && !pready && !pwrite && paddr == uss_pkg::USS_QEN_ALIAS_ADDR // [RULE15]
		|=> prdata == {31'h0, $past(s_r.fifo_en)})
		else $error("enable alias read wrong");
	rd_trig_a: assert property (acc && !pready && !pwrite && paddr == uss_pkg::USS_RXTH_ALIAS_ADDR // [RULE15]
		|=> prdata == {30'h0, $past(s_r.rx_trig)})
		else $error("trigger alias read wrong");
	wr_no_data_a: assert property (acc && !pready && pwrite
		|=> prdata == 32'h0)
		else $error("write returned data");
	mapped_ok_a: assert property (acc && !pready && hit
		|=> !pslverr)
		else $error("mapped access flagged");
	unmapped_keep_a: assert property (acc && !hit
		|=> $stable(s_r.line_control_reg) && $stable(s_r.modem_control_reg) && $stable(s_r.mask))
		else $error("unmapped write took effect");
	reset_pair_a: assert property ( // [RULE9]
		tx_queue_reset == rx_queue_reset)
		else $error("queue resets not paired");
	qreset_event_a: assert property (tx_queue_reset // [RULE10]
		|-> s_r.status[uss_pkg::USS_EV_QRESET])
		else $error("queue reset event missed");
	avail_event_a: assert property (rx_avail && !s_r.avail_d // [RULE13]
		|=> s_r.status[uss_pkg::USS_EV_RX_AVAIL])
		else $error("data available event missed");
	irq_off_a: assert property (!(|(s_r.status & s_r.mask))
		|-> !irq)
		else $error("interrupt without cause");
	pready_pulse_a: assert property (pready
		|=> !pready)
		else $error("pready held too long");
	pready_cause_a: assert property (pready
		|-> $past(acc))
		else $error("pready without access");
endmodule // uss_ctrl

// File: pkg/uss_pkg.sv
/*
 * constants of the uart shadow control block: register
 * addresses, field positions, reset values, event bits and counts.
 * assumes a 32-bit apb with byte addresses and one word per register.
 */
// Summary of operation
// RULE1 - break alias and line control bit share storage
// RULE2 - break set forces transmit output low
// RULE3 - without loopback, line held low during break
// RULE4 - infrared mode break pulses infrared output continuously
// RULE5 - loopback break goes to own receiver only
// RULE6 - dma alias writes only the dma mode bit
// RULE7 - dma bit selects signalling mode zero or one
// RULE8 - queue enable alias writes only enable bit
// RULE9 - enable bit switches both queues together
// RULE10 - enable falling resets both queue controls
// RULE11 - threshold alias writes only the trigger field
// RULE12 - trigger codes: one, quarter, half, full minus two
// RULE13 - data available raised at selected fill level
// RULE14 - mode one receive request at trigger level
// RULE15 - aliases reset zero, upper bits read zero
// RULE16 - mode zero single transfers, mode one thresholds
package uss_pkg;
	// -----------------------------------------------------------------
	// register addresses
	// -----------------------------------------------------------------
	localparam logic [31:0] USS_BREAK_ALIAS_ADDR = 32'h5000_1190;
	localparam logic [31:0] USS_DMA_ALIAS_ADDR = 32'h5000_1194;
	localparam logic [31:0] USS_QEN_ALIAS_ADDR = 32'h5000_1198;
	localparam logic [31:0] USS_RXTH_ALIAS_ADDR = 32'h5000_119c;
	localparam logic [31:0] USS_QCR_ADDR = 32'h5000_1108;
	localparam logic [31:0] USS_LCR_ADDR = 32'h5000_110c;
	localparam logic [31:0] USS_MCR_ADDR = 32'h5000_1110;
	localparam logic [31:0] USS_STATUS_ADDR = 32'h5000_11b0;
	localparam logic [31:0] USS_MASK_ADDR = 32'h5000_11b4;
	// -----------------------------------------------------------------
	// field positions and reset values
	// -----------------------------------------------------------------
	localparam int USS_LCR_BREAK_BIT = 6;
	localparam int USS_MCR_LOOP_BIT = 4;
	localparam int USS_MCR_SIR_BIT = 6;
	localparam int USS_QCR_EN_BIT = 0;
	localparam int USS_QCR_DMA_BIT = 3;
	localparam int USS_QCR_TRIG_LSB = 6;
	localparam logic [7:0] USS_LCR_RST = 8'h00;
	localparam logic [7:0] USS_MCR_RST = 8'h00;
	localparam logic [1:0] USS_TRIG_RST = 2'h0;
	localparam logic [1:0] USS_TRIG_ONE = 2'h0;
	localparam logic [1:0] USS_TRIG_QUARTER = 2'h1;
	localparam logic [1:0] USS_TRIG_HALF = 2'h2;
	localparam logic [1:0] USS_TRIG_FULL_M2 = 2'h3;
	localparam int USS_EV_RX_AVAIL = 0;
	localparam int USS_EV_QRESET = 1;
	localparam int USS_EV_W = 2;
	// -----------------------------------------------------------------
	// counts
	// -----------------------------------------------------------------
	localparam int USS_QUEUE_DEPTH = 16;
	localparam int USS_SIR_PERIOD = 16;
	localparam int USS_SIR_PULSE = 3;
endpackage

// File: verilog/uss_line_drv.sv
/*
 * serial line driver: applies break, loopback and infrared pulsing to
 * the transmitter's serial bit. assumes tx_serial idles high.
 */
`timescale 1ns/1ps
module uss_line_drv #(
	parameter int SIR_PERIOD = uss_pkg::USS_SIR_PERIOD,
	parameter int SIR_PULSE = uss_pkg::USS_SIR_PULSE
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic brk,
	input wire logic loopback,
	input wire logic sir_mode,
	input wire logic tx_serial,
	output logic sout,
	output logic sir_out_n,
	output logic loop_rx
);
	localparam int CW = $clog2(SIR_PERIOD);
	typedef struct packed {
		logic sout;
		logic sir_n;
		logic loop_rx;
		logic [CW-1:0] cnt;
	} uss_line_state_t;
	uss_line_state_t s_r, s_nxt;
	logic bit_val;

	always_comb begin
		s_nxt = s_r;
		bit_val = brk ? 1'b0 : tx_serial; // [RULE2]
		s_nxt.cnt = (s_r.cnt == CW'(SIR_PERIOD - 1)) ? '0 : s_r.cnt + 1'b1;
		s_nxt.sout = loopback ? 1'b1 : bit_val; // [RULE3] [RULE5]
		s_nxt.loop_rx = loopback ? bit_val : 1'b1; // [RULE5]
		// a spacing bit, break included, becomes a short low pulse each period
		s_nxt.sir_n = ~(sir_mode & ~loopback & ~bit_val & (s_r.cnt < CW'(SIR_PULSE))); // [RULE4]
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '{sout: 1'b1, sir_n: 1'b1, loop_rx: 1'b1, cnt: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sout = s_r.sout;
	assign sir_out_n = s_r.sir_n;
	assign loop_rx = s_r.loop_rx;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	break_low_a: assert property (brk && !loopback |=> !sout) else $error("break not low"); // [RULE3]
	loop_quiet_a: assert property (loopback && brk |=> sout && !loop_rx) else $error("loop break leaks"); // [RULE5]
	sir_pulse_a: assert property (sir_mode && brk && !loopback && s_r.cnt == '0 // [RULE4]
		|=> !sir_out_n)
		else $error("no infrared pulse");
endmodule // uss_line_drv

// File: verilog/uss_rx_thresh.sv
/*
 * receive threshold and dma request logic. assumes the fill levels come
 * from the queues in the same clock domain.
 */
`timescale 1ns/1ps
module uss_rx_thresh #(
	parameter int DEPTH = uss_pkg::USS_QUEUE_DEPTH,
	parameter int LW = $clog2(DEPTH) + 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] rx_threshold_select,
	input wire logic queue_en,
	input wire logic dma_mode,
	input wire logic [LW-1:0] rx_level,
	input wire logic [LW-1:0] tx_level,
	output logic rx_avail,
	output logic dma_rx_req_n,
	output logic dma_tx_req_n
);
	typedef struct packed {
		logic avail;
		logic rx_n;
		logic tx_n;
	} uss_thr_state_t;
	uss_thr_state_t s_r, s_nxt;
	logic [LW-1:0] th;

	always_comb begin
		unique case (rx_threshold_select) // [RULE12]
			uss_pkg::USS_TRIG_ONE: th = LW'(1);
			uss_pkg::USS_TRIG_QUARTER: th = LW'(DEPTH / 4);
			uss_pkg::USS_TRIG_HALF: th = LW'(DEPTH / 2);
			uss_pkg::USS_TRIG_FULL_M2: th = LW'(DEPTH - 2);
		endcase
		if (!queue_en) begin
			th = LW'(1); // [RULE9]
		end
		s_nxt.avail = rx_level >= th; // [RULE13]
		if (dma_mode && queue_en) begin // [RULE7]
			s_nxt.rx_n = ~(rx_level >= th); // [RULE14] [RULE16]
			s_nxt.tx_n = ~(tx_level < LW'(DEPTH / 2)); // [RULE16]
		end else begin
			s_nxt.rx_n = ~(rx_level != '0); // [RULE16]
			s_nxt.tx_n = ~(tx_level == '0); // [RULE16]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '{avail: 1'b0, rx_n: 1'b1, tx_n: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rx_avail = s_r.avail;
	assign dma_rx_req_n = s_r.rx_n;
	assign dma_tx_req_n = s_r.tx_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	avail_level_a: assert property (rx_level >= th |=> rx_avail) else $error("avail missed"); // [RULE13]
	mode1_req_a: assert property (dma_mode && queue_en && rx_level >= th |=> !dma_rx_req_n) // [RULE14]
		else $error("mode one rx request missed");
	mode0_req_a: assert property (!dma_mode && rx_level == '0 |=> dma_rx_req_n) // [RULE16]
		else $error("mode zero request without data");
endmodule // uss_rx_thresh

// File: test/uss_remote_rx.sv
/*
 * remote serial device model: watches the serial line and the infrared
 * output of the block. assumes it shares the block's clock and reset.
 */
`timescale 1ns/1ps
module uss_remote_rx (
	input wire logic clk,
	input wire logic rst,
	input wire logic sout,
	input wire logic sir_out_n,
	output logic [15:0] low_run,
	output logic [15:0] sir_falls
);
	logic sir_q;
	// length of the current spacing run on the line
	// falling edges of the infrared output
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_run <= 16'h0000;
			sir_falls <= 16'h0000;
			sir_q <= 1'b1;
		end else begin
			sir_q <= sir_out_n;
			low_run <= sout ? 16'h0000 : low_run + 16'h0001;
			if (sir_q && !sir_out_n) begin
				sir_falls <= sir_falls + 16'h0001;
			end
		end
	end
endmodule // uss_remote_rx

// File: test/tb_top.sv
/*
 * self-checking bench of the shadow control block over apb.
 * assumes the block answers each access with pready and one clock.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
	localparam logic [31:0] A_BRK = uss_pkg::USS_BREAK_ALIAS_ADDR;
	localparam logic [31:0] A_DMA = uss_pkg::USS_DMA_ALIAS_ADDR;
	localparam logic [31:0] A_QEN = uss_pkg::USS_QEN_ALIAS_ADDR;
	localparam logic [31:0] A_RXTH = uss_pkg::USS_RXTH_ALIAS_ADDR;
	localparam logic [31:0] A_QCR = uss_pkg::USS_QCR_ADDR;
	localparam logic [31:0] A_LCR = uss_pkg::USS_LCR_ADDR;
	localparam logic [31:0] A_MCR = uss_pkg::USS_MCR_ADDR;
	localparam logic [31:0] A_ST = uss_pkg::USS_STATUS_ADDR;
	localparam logic [31:0] A_MSK = uss_pkg::USS_MASK_ADDR;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, tx_serial = 1;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd_d;
	logic [4:0] rx_level = 0, tx_level = 0;
	logic pready, pslverr, rd_e, sout, sir_out_n, loop_rx, queue_en, irq;
	logic tx_queue_reset, rx_queue_reset, dma_rx_req_n, dma_tx_req_n;
	logic [15:0] low_run, sir_falls, f0;
	int fails = 0, check_count = 0, txr = 0, rxr = 0, th;
	uss_ctrl #(.DEPTH(16)) i_uss_ctrl (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_serial(tx_serial),
		.rx_level(rx_level), .tx_level(tx_level), .sout(sout), .sir_out_n(sir_out_n),
		.loop_rx(loop_rx), .queue_en(queue_en), .tx_queue_reset(tx_queue_reset),
		.rx_queue_reset(rx_queue_reset), .dma_rx_req_n(dma_rx_req_n),
		.dma_tx_req_n(dma_tx_req_n), .irq(irq));
	uss_remote_rx i_uss_remote_rx (.clk(clk), .rst(rst), .sout(sout),
		.sir_out_n(sir_out_n), .low_run(low_run), .sir_falls(sir_falls));
	initial begin
		forever #20 clk = ~clk;
	end
	// count queue reset pulses
	always @(posedge clk) begin
		txr <= txr + tx_queue_reset;
		rxr <= rxr + rx_queue_reset;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic io(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			finish_test;
		end
		rd_d = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic finish_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#(40 * 20000);
		fails++;
		finish_test;
	end
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		wt(16);
		rst <= 1'b0;
		io(0, A_BRK, 0); `CHK(rd_d, 32'h0)
		io(0, A_DMA, 0); `CHK(rd_d, 32'h0)
		io(0, A_QEN, 0); `CHK(rd_d, 32'h0)
		io(0, A_RXTH, 0); `CHK(rd_d, 32'h0)
		io(0, 32'h5000_1000, 0); `CHK({rd_e, rd_d}, 33'h100000000)
		// break through the alias, seen in line control
		io(1, A_BRK, 32'hffff_ffff);
		io(0, A_BRK, 0); `CHK(rd_d, 32'h1)
		io(0, A_LCR, 0); `CHK(rd_d, 32'h40)
		wt(12); `CHK(sout, 1'b0)
		`CHK(low_run >= 16'd12, 1'b1)
		io(1, A_LCR, 0);
		io(0, A_BRK, 0); `CHK(rd_d, 32'h0)
		wt(2); `CHK(sout, 1'b1)
		// loopback keeps break off the line
		io(1, A_MCR, 32'h10);
		io(1, A_BRK, 1);
		wt(2); `CHK({sout, loop_rx}, 2'b10)
		io(1, A_BRK, 0);
		tx_serial <= 1'b0;
		wt(2); `CHK({sout, loop_rx}, 2'b10)
		tx_serial <= 1'b1;
		wt(2); `CHK(loop_rx, 1'b1)
		// infrared pulses while break is set, none on an idle line
		io(1, A_MCR, 32'h40);
		f0 = sir_falls;
		wt(32); `CHK(sir_falls - f0, 16'd0)
		io(1, A_BRK, 1);
		wt(2);
		f0 = sir_falls;
		wt(32); `CHK(sir_falls - f0, 16'd2)
		io(1, A_BRK, 0);
		io(1, A_MCR, 0);
		// dma alias and trigger alias touch only their own bits
		io(1, A_QCR, 32'h81);
		io(1, A_DMA, 1);
		io(0, A_QCR, 0); `CHK(rd_d, 32'h89)
		`CHK(queue_en, 1'b1)
		io(1, A_ST, 3);
		io(1, A_MSK, 1);
		`CHK(irq, 1'b0)
		for (int c = 0; c < 4; c++) begin
			th = (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 14;
			io(1, A_RXTH, c);
			io(0, A_QCR, 0); `CHK(rd_d, {24'h0, c[1:0], 6'h09})
			rx_level <= 5'(th - 1);
			wt(3); `CHK(dma_rx_req_n, 1'b1)
			rx_level <= 5'(th);
			wt(3); `CHK(dma_rx_req_n, 1'b0)
		end
		io(0, A_ST, 0); `CHK(rd_d[0], 1'b1)
		`CHK(irq, 1'b1)
		tx_level <= 5'd7;
		wt(3); `CHK(dma_tx_req_n, 1'b0)
		tx_level <= 5'd8;
		wt(3); `CHK(dma_tx_req_n, 1'b1)
		// mode zero: single transfer requests
		io(1, A_DMA, 0);
		io(0, A_QCR, 0); `CHK(rd_d, 32'hc1)
		rx_level <= 5'd1;
		tx_level <= 5'd0;
		wt(3); `CHK({dma_rx_req_n, dma_tx_req_n}, 2'b00)
		rx_level <= 5'd0;
		tx_level <= 5'd1;
		wt(3); `CHK({dma_rx_req_n, dma_tx_req_n}, 2'b11)
		// disabling the queues resets both and raises the event
		io(1, A_ST, 3);
		io(1, A_MSK, 2);
		f0 = 16'(txr);
		io(1, A_QEN, 0);
		wt(3); `CHK({16'(txr) - f0, 16'(rxr) - f0}, {16'd1, 16'd1})
		`CHK(queue_en, 1'b0)
		io(0, A_QCR, 0); `CHK(rd_d, 32'hc0)
		io(0, A_ST, 0); `CHK(rd_d[1], 1'b1)
		`CHK(irq, 1'b1)
		io(1, A_MSK, 0);
		wt(2); `CHK(irq, 1'b0)
		io(1, A_MSK, 2);
		io(1, A_ST, 2);
		wt(2); `CHK(irq, 1'b0)
		io(1, A_QEN, 0);
		wt(3); `CHK(16'(txr) - f0, 16'd1)
		finish_test;
	end
endmodule // tb_top
